/* rtl/irq_status_pkg.sv */
// Constants for the interrupt status register of the quad D/A card
package irq_status_pkg;
	localparam int          DATA_W         = 32;           // Register word width
	localparam int          NUM_QDAC       = 8;            // Quad converters on the card
	localparam int          NUM_FIFO       = 32;           // FIFOs feeding the summary flag
	localparam int          RSVD_HI        = 31;           // Top of the unused field
	localparam int          RSVD_LO        = 25;           // Bottom of the unused field
	localparam int          FIFO_FLAG_POS  = 24;           // Summary FIFO flag position
	localparam int          SEQ_FLAG_LO    = 16;           // Converter one sequencer flag
	localparam int          SEQ_FLAG_HI    = 23;           // Converter eight sequencer flag
	localparam logic        FLAG_RESET     = 1'b0;         // Every defined flag resets low
	localparam logic [31:0] RDATA_RESET    = 32'h00000000; // Read data after reset
	localparam logic [31:0] FIFO_RESET     = 32'h00000000; // Per-FIFO source bits after reset
	localparam logic [6:0]  RSVD_READ      = 7'h00;        // Value returned from the unused field
endpackage : irq_status_pkg

/* rtl/sticky_flags.sv */
// Bank of sticky flags: set on an event, cleared by a strobe, set wins
`timescale 1ns/10ps
module sticky_flags #(
	parameter int WIDTH = 8
) (
	input  wire logic             sys_clk, // System clock
	input  wire logic             arst_n,  // Asynchronous reset, active low
	input  wire logic [WIDTH-1:0] set_i,   // Event pulses, one per flag
	input  wire logic [WIDTH-1:0] clr_i,   // Clear strobes, one per flag
	output logic      [WIDTH-1:0] flag_q   // Held flags
);
	// A set in the same cycle as a clear keeps the flag high
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			flag_q <= '0;
		end else begin
			flag_q <= set_i | (flag_q & ~clr_i);
		end
	end
endmodule : sticky_flags

/* rtl/dac_interrupt_status.sv */
// Interrupt status register: FIFO summary flag, sequencer flags and host request
//
// Functional notes
// [R1] Unused bits 31:25 ignore writes; reads return zero there.
// [R2] One summary flag at bit 24 gathers events of all enabled FIFOs.
// [R3] Summary sets when an enabled FIFO drops below threshold or runs empty.
// [R4] Summary is read-only; clears itself once all enabled FIFOs refill above limit.
// [R5] Software keeps FIFO interrupts off for converters not in FIFO mode.
// [R6] Per-FIFO source indications are kept outside this register, on their own port.
// [R7] One sequencer flag per converter; converter eight at bit 23, three at 18.
// [R8] A sequencer flag sets on its sequence event only while enabled.
// [R9] Writing 1 clears a sequencer flag; writing 0 leaves it.
// [R10] Converters two and one sit at bits 17 and 16.
// [R11] Interrupt request is high while any flag here is set.
`timescale 1ns/10ps
module dac_interrupt_status
	import irq_status_pkg::*;
(
	input  wire logic [DATA_W-1:0]   sys_clk_unused_guard, // Unused, tie low
	input  wire logic                sys_clk,             // System clock, 25 MHz
	input  wire logic                arst_n,              // Asynchronous reset, active low
	input  wire logic                reg_wr,              // Write strobe to the status word
	input  wire logic [DATA_W-1:0]   reg_wdata,           // Write data
	input  wire logic                reg_rd,              // Read strobe of the status word
	output logic      [DATA_W-1:0]   reg_rdata,           // Read data, registered
	input  wire logic [NUM_FIFO-1:0] fifo_irq_enable,     // Per-FIFO interrupt enables
	input  wire logic [NUM_FIFO-1:0] fifo_below_limit,    // FIFO count below threshold
	input  wire logic [NUM_FIFO-1:0] fifo_empty,          // FIFO holds no unconverted values
	input  wire logic [NUM_FIFO-1:0] fifo_above_limit,    // FIFO refilled above its limit
	input  wire logic [NUM_QDAC-1:0] seq_irq_enable,      // Per-converter sequencer enables
	input  wire logic [NUM_QDAC-1:0] seq_event,           // Sequence event pulses
	output logic [NUM_FIFO-1:0]      fifo_irq_source,     // Which FIFOs raised the summary
	output logic                     fifo_level_irq_flag, // Summary FIFO flag
	output logic [NUM_QDAC-1:0]      seq_irq_flag,        // Sequencer flags, converter 1 at bit 0
	output logic                     irq_req              // Interrupt request to the host
);
	logic                fifo_flag_q;
	logic                fifo_flag_d;
	logic [NUM_FIFO-1:0] fifo_src_q;
	logic [NUM_FIFO-1:0] fifo_hit;
	logic                fifo_all_refilled;
	logic [NUM_QDAC-1:0] seq_set;
	logic [NUM_QDAC-1:0] seq_clr;
	logic [DATA_W-1:0]   status_word;

	// FIFO events that count toward the summary
	assign fifo_hit          = (fifo_below_limit | fifo_empty) & fifo_irq_enable;  // [R2] [R3]
	assign fifo_all_refilled = &(fifo_above_limit | ~fifo_irq_enable);             // [R4]

	// Summary flag: set on any hit, self-clears when all enabled FIFOs refilled
	always_comb begin
		fifo_flag_d = fifo_flag_q;
		if (|fifo_hit) begin
			fifo_flag_d = 1'b1; // [R3]
		end else if (fifo_all_refilled) begin
			fifo_flag_d = FLAG_RESET; // [R4]
		end
	end

	// Summary flag register; software writes never touch it
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			fifo_flag_q <= FLAG_RESET;
		end else begin
			fifo_flag_q <= fifo_flag_d; // [R4]
		end
	end

	// Per-FIFO source bits kept beside the register, cleared on refill
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			fifo_src_q <= FIFO_RESET;
		end else begin
			fifo_src_q <= fifo_hit | (fifo_src_q & ~fifo_above_limit); // [R6]
		end
	end

	// Sequencer flag set and write-one-to-clear strobes
	assign seq_set = seq_event & seq_irq_enable;                                    // [R8]
	assign seq_clr = reg_wr ? reg_wdata[SEQ_FLAG_HI:SEQ_FLAG_LO] : '0;             // [R9]

	// One sticky flag per converter
	sticky_flags #(
		.WIDTH (NUM_QDAC)
	) u_seq_flags (
		.sys_clk (sys_clk),
		.arst_n  (arst_n),
		.set_i   (seq_set),
		.clr_i   (seq_clr),
		.flag_q  (seq_irq_flag)
	);

	// Assemble the status word; bits below 16 belong to other logic
	always_comb begin
		status_word                            = '0;
		status_word[RSVD_HI:RSVD_LO]           = RSVD_READ;     // [R1]
		status_word[FIFO_FLAG_POS]             = fifo_flag_q;   // [R2]
		status_word[SEQ_FLAG_HI:SEQ_FLAG_LO]   = seq_irq_flag;  // [R7] [R10]
	end

	// Read data captured on the read strobe
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			reg_rdata <= RDATA_RESET;
		end else if (reg_rd) begin
			reg_rdata <= status_word;
		end
	end

	// Outputs
	assign fifo_level_irq_flag = fifo_flag_q;
	assign fifo_irq_source     = fifo_src_q;
	assign irq_req             = fifo_flag_q | (|seq_irq_flag); // [R11]
endmodule : dac_interrupt_status

/* sim/irq_chk_asserts.sv */
// Checker for the interrupt status register
`timescale 1ns/10ps
module irq_chk (
	input wire logic        sys_clk, arst_n, reg_wr, reg_rd, fifo_level_irq_flag, irq_req,
	input wire logic [31:0] reg_wdata, reg_rdata, fifo_irq_enable, fifo_below_limit, fifo_empty,
	fifo_above_limit,
	input wire logic [7:0]  seq_irq_enable, seq_event, seq_irq_flag
);
	// Hit, refill, event and clear terms
	wire logic       h  = |(fifo_irq_enable & (fifo_below_limit | fifo_empty));
	wire logic       f  = &(~fifo_irq_enable | fifo_above_limit);
	wire logic [7:0] ev = seq_event & seq_irq_enable;
	wire logic [7:0] cl = reg_wr ? reg_wdata[23:16] : 8'h00;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!arst_n);
	property p_fs; h |=> fifo_level_irq_flag; endproperty
	a_fs: assert property (p_fs) else $error("fifo set");
	property p_fc; !h && f |=> !fifo_level_irq_flag; endproperty
	a_fc: assert property (p_fc) else $error("fifo clear");
	property p_ss; ev != 0 |=> (seq_irq_flag & $past(ev)) == $past(ev); endproperty
	a_ss: assert property (p_ss) else $error("seq set");
	property p_sn; 1'b1 |=> (seq_irq_flag & ~$past(seq_irq_flag) & ~$past(ev)) == 0; endproperty
	a_sn: assert property (p_sn) else $error("seq spurious");
	property p_sh; 1'b1 |=> (seq_irq_flag & $past(seq_irq_flag & ~cl)) == $past(seq_irq_flag & ~cl); endproperty
	a_sh: assert property (p_sh) else $error("seq hold");
	property p_sc; reg_wr |=> (seq_irq_flag & $past(cl & ~ev)) == 0; endproperty
	a_sc: assert property (p_sc) else $error("seq clear");
	property p_rd; reg_rd |=> reg_rdata == {7'h00, $past(fifo_level_irq_flag), $past(seq_irq_flag), 16'h0000}; endproperty
	a_rd: assert property (p_rd) else $error("read word");
	property p_irq; irq_req == (fifo_level_irq_flag || (|seq_irq_flag)); endproperty
	a_irq: assert property (p_irq) else $error("request");
endmodule : irq_chk
bind dac_interrupt_status irq_chk u_chk (.*);

/* sim/tb_dac_interrupt_status.sv */
// Self-checking bench for the interrupt status register
`timescale 1ns/10ps
module tb_dac_interrupt_status;
	logic        sys_clk = 0, arst_n = 0, reg_wr = 0, reg_rd = 0, fifo_level_irq_flag, irq_req;
	logic [31:0] sys_clk_unused_guard = 0, reg_wdata = 0, reg_rdata, fifo_irq_enable = 0, fifo_irq_source;
	logic [31:0] fifo_below_limit = 0, fifo_empty = 0, fifo_above_limit = 0;
	logic [7:0]  seq_irq_enable = 0, seq_event = 0, seq_irq_flag;
	int          n_mismatch = 0, num_checks = 0;
	dac_interrupt_status DUT (.*);
	initial forever #20 sys_clk = ~sys_clk;
	// Compare and count
	task automatic chk(logic [31:0] got, logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: %h vs %h", $time, got, exp);
		end
	endtask : chk
	task automatic conclude;
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : conclude
	// Wait edges, then step just past the last one
	task automatic cyc(int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask : cyc
	// One-cycle write or read strobe, then one idle edge
	task automatic xf(logic w, logic [31:0] d);
		{reg_wr, reg_rd, reg_wdata} = {w, !w, d};
		cyc(1);
		{reg_wr, reg_rd} = 2'b00;
		cyc(1);
	endtask : xf
	// Sequencer flags: only enabled converters set, write-1 clears
	task automatic t_seq;
		{seq_irq_enable, seq_event} = 16'h55ff;
		cyc(1);
		seq_event = 8'h00;
		xf(0, 0);
		chk(reg_rdata, 32'h00550000);
		xf(1, 32'h0005ffff);
		xf(0, 0);
		chk(reg_rdata, 32'h00500000);
		xf(1, 32'h00500000);
		chk(irq_req, 0);
	endtask : t_seq
	// Summary flag: disabled FIFO ignored, set, read-only, self clear
	task automatic t_fifo;
		{fifo_irq_enable, fifo_empty} = {32'h80000001, 32'h00000020};
		cyc(2);
		chk(fifo_level_irq_flag, 0);
		fifo_below_limit = 32'h80000000;
		cyc(1);
		chk(fifo_irq_source, 32'h80000000);
		fifo_below_limit = 0;
		xf(1, 32'h01ffffff);
		xf(0, 0);
		chk(reg_rdata, 32'h01000000);
		fifo_above_limit = 32'h80000001;
		cyc(1);
		chk(irq_req, 0);
		fifo_empty = 32'h00000021;
		cyc(1);
		chk(fifo_level_irq_flag, 1);
		fifo_empty = 0;
		cyc(1);
		chk(fifo_level_irq_flag, 0);
	endtask : t_fifo
	initial begin
		cyc(10);
		arst_n = 1;
		t_seq;
		t_fifo;
		conclude;
	end
	// Hang guard
	initial begin
		#100000;
		n_mismatch++;
		conclude;
	end
endmodule : tb_dac_interrupt_status
